// ==== design/tmr_timer8.sv ====
// Function
// - 8-bit counter counts up once per timer tick.
// - Two read views show the counter; alternate view never clears overflow.
// - Writing either view reloads FCh; reset also starts at FCh.
// - Clock select picks cpu/2, cpu/4, cpu/8 or osc/8000.
// - Rollover FFh to 00h sets the overflow flag in every mode.
// - Overflow interrupt only when enabled and global mask clear.
// - Overflow flag clears after status read then primary view access.
// - Wait mode does not affect counting.
// - Halt freezes the counter; reset restarts it at FCh.
// - Active capture edge latches counter into the channel register.
// - Capture sets its flag; interrupt gated by enable and mask.
// - Capture flag clears after status read then capture access.
// - One capture enable gates both capture channels.
// - In single pulse or PWM mode only channel 2 captures.
// - Capture pins always see transitions, even when driven as outputs.
// - Two compare registers, software only, reset to 00h.
// - Match sets compare flag, drives level, interrupt if enabled.
// - Compare pin latch held low during reset.
// - Compare flag clears after status read then compare access.
// - Pin enable clear leaves pin as I/O; match still flags.
// - Div-2 matches at value; slower ticks at value plus one.
// - Force bit copies level to pin without flag; off in modes.
`timescale 1ns/1ps
module tmr_timer8
  import tmr_pkg::*;
#(
  parameter int OSC_DIV_P = OSC_DIV
)(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Power and CPU state
  input  wire logic             halt_mode,
  input  wire logic             wait_mode,
  input  wire logic             global_irq_mask,
  input  wire logic             osc_tick,
  // Configuration
  input  wire logic [1:0]       timer_clock_select,
  input  wire logic             overflow_irq_enable,
  input  wire logic             capture_irq_enable,
  input  wire logic             compare_irq_enable,
  input  wire logic [1:0]       capture_edge_select,
  input  wire logic [1:0]       compare_output_level,
  input  wire logic [1:0]       compare_pin_enable,
  input  wire logic [1:0]       force_level_strobe,
  input  wire logic             single_pulse_mode,
  input  wire logic             pwm_mode,
  // Register accesses, one-cycle strobes
  input  wire logic             status_read,
  input  wire logic             primary_access,
  input  wire logic             counter_write,
  input  wire logic [1:0]       capture_access,
  input  wire logic [1:0]       compare_access,
  input  wire logic [1:0]       compare_write,
  input  wire logic [CNT_W-1:0] compare_wdata,
  // Pins
  input  wire logic [1:0]       capture_input_pin,
  output logic [1:0]            compare_output_pin,
  output logic [1:0]            compare_output_oe,
  // Register views
  output logic [CNT_W-1:0]      counter_primary_view,
  output logic [CNT_W-1:0]      counter_alternate_view,
  output logic [CNT_W-1:0]      capture_value_reg [2],
  output logic [CNT_W-1:0]      compare_value_reg [2],
  output logic                  overflow_flag,
  output logic [1:0]            capture_flag,
  output logic [1:0]            compare_flag,
  // Interrupt request
  output logic                  timer_irq
);
  logic [CNT_W-1:0] count_reg;
  logic             tick;
  logic             run;
  logic             mode_on;
  logic             overflow;
  logic [1:0]       cap_hit;
  logic [1:0]       cap_en;
  logic [1:0]       cmp_hit;
  logic             ovf_armed_reg;
  logic [1:0]       cap_armed_reg;
  logic [1:0]       cmp_armed_reg;
  logic [1:0]       pin_reg;
  logic [CNT_W-1:0] cap_val [2];

  // Wait mode is deliberately ignored; only halt stops the prescaler
  assign run = !halt_mode;
  assign mode_on = single_pulse_mode || pwm_mode;

  tmr_prescaler #(
    .OSC_DIV_P (OSC_DIV_P)
  ) u_pre (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (run),
    .clk_sel  (timer_clock_select),
    .osc_tick (osc_tick),
    .tick     (tick)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      count_reg <= CNT_RESET;
    else if (counter_write)
      count_reg <= CNT_RESET;
    else if (tick)
      count_reg <= count_reg + 8'h01;
  end

  assign counter_primary_view   = count_reg;
  assign counter_alternate_view = count_reg;
  assign overflow = tick && !counter_write && (count_reg == CNT_MAX);

  // Overflow flag: set beats clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      overflow_flag <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end
    else
    begin
      if (status_read && overflow_flag)
        ovf_armed_reg <= 1'b1;
      else if (primary_access)
        ovf_armed_reg <= 1'b0;
      if (overflow)
        overflow_flag <= 1'b1;
      else if (primary_access && ovf_armed_reg)
        overflow_flag <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_ch
      // Channel 1 is taken by the pulse modes
      assign cap_en[i] = (i == 1) || !mode_on;

      tmr_capture_chan u_cap (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .pin_in      (capture_input_pin[i]),
        .edge_rising (capture_edge_select[i]),
        .enable      (cap_en[i]),
        .count       (count_reg),
        .capture     (cap_hit[i]),
        .value       (cap_val[i])
      );
      assign capture_value_reg[i] = cap_val[i];

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          capture_flag[i]  <= 1'b0;
          cap_armed_reg[i] <= 1'b0;
        end
        else
        begin
          if (status_read && capture_flag[i])
            cap_armed_reg[i] <= 1'b1;
          else if (capture_access[i])
            cap_armed_reg[i] <= 1'b0;
          if (cap_hit[i])
            capture_flag[i] <= 1'b1;
          else if (capture_access[i] && cap_armed_reg[i])
            capture_flag[i] <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
          compare_value_reg[i] <= CMP_RESET;
        else if (compare_write[i])
          compare_value_reg[i] <= compare_wdata;
      end

      // Flag and pin update on the tick that loads the next count, so with
      // div-2 they change as the counter reaches the value, otherwise one
      // count later
      always_comb
      begin
        if (timer_clock_select == CS_DIV2)
          cmp_hit[i] = tick
            && (count_reg + CMP_LAG == compare_value_reg[i]);
        else
          cmp_hit[i] = tick && (count_reg == compare_value_reg[i]);
      end

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          compare_flag[i]  <= 1'b0;
          cmp_armed_reg[i] <= 1'b0;
        end
        else
        begin
          if (status_read && compare_flag[i])
            cmp_armed_reg[i] <= 1'b1;
          else if (compare_access[i])
            cmp_armed_reg[i] <= 1'b0;
          if (cmp_hit[i])
            compare_flag[i] <= 1'b1;
          else if (compare_access[i] && cmp_armed_reg[i])
            compare_flag[i] <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
          pin_reg[i] <= 1'b0;
        else if (force_level_strobe[i] && !mode_on)
          pin_reg[i] <= compare_output_level[i];
        else if (cmp_hit[i])
          pin_reg[i] <= compare_output_level[i];
      end

      assign compare_output_oe[i]  = compare_pin_enable[i];
      assign compare_output_pin[i] = compare_pin_enable[i] && pin_reg[i];
    end
  endgenerate

  // Pending requests wait for enable and an open mask
  assign timer_irq = !global_irq_mask
    && ((overflow_irq_enable && overflow_flag)
     || (capture_irq_enable && |capture_flag)
     || (compare_irq_enable && |compare_flag));
endmodule

// ==== shared/tmr_pkg.sv ====
package tmr_pkg;
  localparam int          CNT_W        = 8;
  localparam logic [7:0]  CNT_RESET    = 8'hFC;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
  localparam logic [7:0]  CMP_RESET    = 8'h00;
  localparam logic [7:0]  CMP_LAG      = 8'h01;
  // Clock select encodings
  localparam logic [1:0]  CS_DIV2      = 2'h0;
  localparam logic [1:0]  CS_DIV4      = 2'h1;
  localparam logic [1:0]  CS_DIV8      = 2'h2;
  localparam logic [1:0]  CS_OSC       = 2'h3;
  localparam int          DIV2_CYC     = 2;
  localparam int          DIV4_CYC     = 4;
  localparam int          DIV8_CYC     = 8;
  localparam int          OSC_DIV      = 8000;
  localparam int          PRE_W        = 13;
endpackage

// ==== design/tmr_prescaler.sv ====
`timescale 1ns/1ps
module tmr_prescaler
  import tmr_pkg::*;
#(
  parameter int OSC_DIV_P = OSC_DIV
)(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  input  wire logic       osc_tick,
  // Tick out
  output logic            tick
);
  logic [2:0]       cpu_div_reg;
  logic [PRE_W-1:0] osc_div_reg;
  logic             osc_hit;

  assign osc_hit = osc_tick && (osc_div_reg == PRE_W'(OSC_DIV_P - 1));

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cpu_div_reg <= 3'h0;
    else if (run)
      cpu_div_reg <= cpu_div_reg + 3'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      osc_div_reg <= '0;
    else if (run && osc_tick)
      osc_div_reg <= osc_hit ? '0 : osc_div_reg + PRE_W'(1);
  end

  always_comb
  begin
    unique case (clk_sel)
      CS_DIV2: tick = run && (cpu_div_reg[0] == 1'b1);
      CS_DIV4: tick = run && (cpu_div_reg[1:0] == 2'h3);
      CS_DIV8: tick = run && (cpu_div_reg == 3'h7);
      CS_OSC:  tick = run && osc_hit;
    endcase
  end
endmodule

// ==== design/tmr_capture_chan.sv ====
`timescale 1ns/1ps
module tmr_capture_chan
  import tmr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Pin and setup
  input  wire logic             pin_in,
  input  wire logic             edge_rising,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] count,
  // Result
  output logic                  capture,
  output logic [CNT_W-1:0]      value
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edge detection works whether the pin is input or driven output
  assign capture = enable && (edge_rising ? (sync_reg && !last_reg)
                                          : (!sync_reg && last_reg));

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      value <= '0;
    else if (capture)
      value <= count;
  end
endmodule

// ==== tb/tmr_chk.sv ====
`timescale 1ns/1ps
module tmr_chk
  import tmr_pkg::*;
(
  // Clock, reset and controls
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic             halt_mode,
  input wire logic             global_irq_mask,
  input wire logic             overflow_irq_enable,
  input wire logic             counter_write,
  input wire logic             primary_access,
  input wire logic [1:0]       compare_pin_enable,
  // Observed outputs
  input wire logic [1:0]       compare_output_pin,
  input wire logic [1:0]       compare_output_oe,
  input wire logic [CNT_W-1:0] counter_primary_view,
  input wire logic [CNT_W-1:0] counter_alternate_view,
  input wire logic             overflow_flag,
  input wire logic [1:0]       compare_flag,
  input wire logic [1:0]       capture_flag,
  input wire logic             timer_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_count_step: assert property (
    $changed(counter_primary_view) && !$past(counter_write) |->
    counter_primary_view == $past(counter_primary_view) + 8'h01)
    else $error("counter skipped a value");
  a_views_same: assert property (
    counter_primary_view == counter_alternate_view)
    else $error("counter views differ");
  a_write_reload: assert property (
    counter_write |=> counter_primary_view == CNT_RESET)
    else $error("write did not reload");
  a_ovf_set: assert property (
    $past(counter_primary_view) == CNT_MAX &&
    counter_primary_view == 8'h00 |-> overflow_flag)
    else $error("rollover without overflow flag");
  a_ovf_irq: assert property (
    overflow_flag && overflow_irq_enable && !global_irq_mask |-> timer_irq)
    else $error("overflow request missing");
  a_mask_blocks: assert property (
    global_irq_mask |-> !timer_irq)
    else $error("request while masked");
  a_ovf_hold: assert property (
    overflow_flag && !primary_access |=> overflow_flag)
    else $error("overflow flag lost");
  a_halt_freeze: assert property (
    halt_mode && !counter_write |=> $stable(counter_primary_view))
    else $error("counter moved in halt");
  a_pin_gate: assert property (
    (compare_output_pin & ~compare_pin_enable) == 2'h0 &&
    compare_output_oe == compare_pin_enable)
    else $error("disabled compare pin driven");
  c_ovf: cover property ($rose(overflow_flag));
  c_cmp: cover property ($rose(compare_flag[0]));
  c_cap: cover property ($rose(capture_flag[1]));
endmodule

bind tmr_timer8 tmr_chk tmr_chk_i (.*);

// ==== tb/tmr_pins.sv ====
`timescale 1ns/1ps
module tmr_pins (
  // Timer pins
  input  wire logic [1:0] compare_output_pin,
  input  wire logic [1:0] compare_output_oe,
  output logic [1:0]      capture_input_pin,
  // Level seen by the load
  output logic [1:0]      pad_level
);
  // Pull-up on the load holds a released compare pad high
  assign pad_level = compare_output_oe & compare_output_pin
                     | ~compare_output_oe;
  initial capture_input_pin = 2'h0;
  // Source drives a capture pin even while used as output
  task automatic flip(input int ch);
    capture_input_pin[ch] = ~capture_input_pin[ch];
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import tmr_pkg::*;
;
  localparam int OSC_P = 4;
  logic             clk_sys, rst_n, halt_mode, wait_mode, global_irq_mask;
  logic             osc_tick, overflow_irq_enable, capture_irq_enable;
  logic             compare_irq_enable, single_pulse_mode, pwm_mode;
  logic             status_read, primary_access, counter_write, timer_irq;
  logic [1:0]       timer_clock_select, capture_edge_select, compare_write;
  logic [1:0]       compare_output_level, compare_pin_enable, pad_level;
  logic [1:0]       force_level_strobe, capture_access, compare_access;
  logic [1:0]       capture_input_pin, compare_output_pin, compare_output_oe;
  logic [1:0]       capture_flag, compare_flag;
  logic             overflow_flag;
  logic [CNT_W-1:0] compare_wdata, counter_primary_view, held;
  logic [CNT_W-1:0] capture_value_reg [2];
  logic [CNT_W-1:0] compare_value_reg [2];
  int               miscompares, cmp_count, cyc, n;

  tmr_timer8 #(.OSC_DIV_P(OSC_P)) tmr_timer8_i (.*,
    .counter_alternate_view());
  tmr_pins tmr_pins_i (.*);

  initial
  begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) osc_tick <= ~osc_tick;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      miscompares++;
      give_verdict;
    end
  end

  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // One-cycle access strobe: 0 status, 1 primary, 2 compare, 3 capture,
  // 4 force, 5 counter write
  task automatic stb(input int w, input int ch);
    step(1);
    case (w)
      0: status_read = 1;
      1: primary_access = 1;
      2: compare_access[ch] = 1;
      3: capture_access[ch] = 1;
      4: force_level_strobe[ch] = 1;
      default: counter_write = 1;
    endcase
    step(1);
    {status_read, primary_access, counter_write} = 3'h0;
    {capture_access, compare_access, force_level_strobe} = 6'h00;
  endtask
  task automatic waitf(input int w);
    n = 0;
    while ((w == 0 ? overflow_flag : w == 1 ? compare_flag[0]
            : capture_flag[1]) !== 1'b1 && n < 3000)
    begin
      step(1);
      n++;
    end
  endtask
  task automatic rate(input int exp);
    int k;
    step(20);
    for (int i = 0; i < 2; i++)
    begin
      held = counter_primary_view;
      k = 0;
      while (counter_primary_view === held && k < 100)
      begin
        step(1);
        k++;
      end
    end
    chk(k[7:0], exp[7:0]);
  endtask

  initial
  begin
    {halt_mode, wait_mode, global_irq_mask, osc_tick} = 4'h0;
    {single_pulse_mode, pwm_mode, status_read} = 3'h0;
    {overflow_irq_enable, capture_irq_enable, compare_irq_enable} = 3'h7;
    {primary_access, counter_write, compare_write} = 4'h0;
    {capture_access, compare_access, force_level_strobe} = 6'h00;
    {timer_clock_select, capture_edge_select} = 4'h3;
    compare_output_level = 2'h3;
    compare_pin_enable = 2'h1;
    compare_wdata = 8'h00;
    {miscompares, cmp_count, cyc} = 96'h0;
    rst_n = 0;
    step(6);
    chk(counter_primary_view, CNT_RESET);
    chk(compare_value_reg[1], CMP_RESET);
    chk({compare_output_pin, compare_flag, overflow_flag}, 8'h00);
    rst_n = 1;
    $display("reset test done");
    waitf(0);
    chk(counter_primary_view, 8'h00);
    chk(timer_irq, 1'b1);
    global_irq_mask = 1;
    #1 chk(timer_irq, 1'b0);
    global_irq_mask = 0;
    stb(1, 0);
    chk(overflow_flag, 1'b1);
    stb(0, 0);
    stb(1, 0);
    chk(overflow_flag, 1'b0);
    stb(5, 0);
    chk(counter_primary_view, CNT_RESET);
    $display("overflow test done");
    wait_mode = 1;
    for (int s = 0; s < 4; s++)
    begin
      timer_clock_select = s[1:0];
      rate(s < 3 ? 2 << s : 2 * OSC_P);
    end
    wait_mode = 0;
    $display("rate test done");
    {overflow_irq_enable, compare_irq_enable} = 2'h0;
    stb(5, 0);
    stb(0, 0);
    stb(2, 0);
    compare_output_level = 2'h0;
    stb(4, 0);
    chk(compare_output_pin, 2'h0);
    chk(compare_flag[0], 1'b0);
    single_pulse_mode = 1;
    compare_output_level = 2'h1;
    stb(4, 0);
    chk(compare_output_pin, 2'h0);
    single_pulse_mode = 0;
    pwm_mode = 1;
    stb(4, 0);
    chk(compare_output_pin, 2'h0);
    pwm_mode = 0;
    compare_irq_enable = 1;
    $display("force test done");
    for (int s = 0; s < 2; s++)
    begin
      timer_clock_select = s[1:0];
      compare_wdata = 8'h40;
      compare_write = 2'h1;
      step(1);
      compare_write = 2'h0;
      stb(5, 0);
      waitf(1);
      chk(counter_primary_view, 8'h40 + s[7:0]);
      chk(compare_output_pin, 2'h1);
      chk(pad_level, 2'h3);
      chk(timer_irq, 1'b1);
      chk(compare_value_reg[0], 8'h40);
      stb(0, 0);
      stb(2, 0);
      chk(compare_flag[0], 1'b0);
    end
    $display("compare test done");
    compare_irq_enable = 0;
    halt_mode = 1;
    step(2);
    held = counter_primary_view;
    single_pulse_mode = 1;
    tmr_pins_i.flip(0);
    tmr_pins_i.flip(1);
    waitf(2);
    step(2);
    chk(capture_value_reg[1], held);
    chk(counter_primary_view, held);
    chk(capture_flag, 2'h2);
    chk(timer_irq, 1'b1);
    stb(0, 0);
    stb(3, 1);
    chk(capture_flag, 2'h0);
    single_pulse_mode = 0;
    capture_edge_select = 2'h0;
    tmr_pins_i.flip(0);
    tmr_pins_i.flip(1);
    step(6);
    chk(capture_flag, 2'h3);
    chk(capture_value_reg[0], held);
    halt_mode = 0;
    $display("capture test done");
    give_verdict;
  end
endmodule
